//--- verilog/dmsc_defines.vh
`ifndef DMSC_DEFINES_VH
`define DMSC_DEFINES_VH

// register indices; byte address is four times the index
`define DMSC_IDX_CTRL6 8'h1e
`define DMSC_IDX_MON 8'h1f
`define DMSC_IDX_CTRL1 8'h40
`define DMSC_IDX_ESTAT 8'h41
`define DMSC_IDX_RS_FIRST 8'h60
`define DMSC_IDX_RS_LAST 8'h6b
`define DMSC_IDX_TS_FIRST 8'h70
`define DMSC_IDX_TS_LAST 8'h7b

// field positions in the receive common control register
`define DMSC_JCRC_BIT 7
`define DMSC_RALIGN_BIT 6
`define DMSC_TALIGN_BIT 5
`define DMSC_SEL_MSB 4
`define DMSC_SEL_LSB 0
// field position in the robbed-bit control register
`define DMSC_FORCE1_BIT 5

// reset values
`define DMSC_CTRL6_RST 8'h00
`define DMSC_CTRL1_RST 8'h00
`define DMSC_MON_RST 8'h00
`define DMSC_SIG_RST 8'h00

// frame geometry
`define DMSC_SIG_REGS 12
`define DMSC_CH_COUNT 5'd24
`define DMSC_FRM_LAST 5'd23
`define DMSC_BIT_LAST 3'd7

// elastic store pointer space: two frames of 193 bits
`define DMSC_ES_DEPTH 10'd386
`define DMSC_ES_LAST 9'd385
`define DMSC_ES_HALF 9'd97

// bus constants
`define DMSC_HSIZE_WORD 3'b010
`define DMSC_HRESP_OKAY 1'b0

`endif

//--- verilog/dmsc_pair_buffer.v
`timescale 1ns/1ps
module dmsc_pair_buffer #(
	parameter WIDTH = 2
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_ce,
	// filling side
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	// draining side
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem0_q;
	reg [WIDTH-1:0] mem1_q;
	reg wptr_q;
	reg rptr_q;
	reg [1:0] cnt_q;
	wire push;
	wire pop;

	// two entries let a stalled reader absorb one word in flight
	assign o_in_ready = (cnt_q != 2'd2);
	assign o_out_valid = (cnt_q != 2'd0);
	assign o_out_data = rptr_q ? mem1_q : mem0_q;
	assign push = i_in_valid & o_in_ready & i_ce;
	assign pop = o_out_valid & i_out_ready & i_ce;

	// storage and pointers
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem0_q <= {WIDTH{1'b0}};
			mem1_q <= {WIDTH{1'b0}};
			wptr_q <= 1'b0;
			rptr_q <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push) begin
				if (wptr_q)
					mem1_q <= i_in_data;
				else
					mem0_q <= i_in_data;
				wptr_q <= ~wptr_q;
			end
			if (pop)
				rptr_q <= ~rptr_q;
			if (push && !pop)
				cnt_q <= cnt_q + 2'd1;
			else if (pop && !push)
				cnt_q <= cnt_q - 2'd1;
		end
	end
endmodule // dmsc_pair_buffer

//--- verilog/dmsc_monitor.v
// Functional notes
// - bit 7 picks Japanese receive CRC6
// - five low bits select monitored channel
// - first received bit lands in bit 7
// - register and pin signaling run together
// - twelve receive and transmit signaling registers
// - force bit clear passes signaling unchanged
// - force bit set drives received robbed positions one on the serial output only
// - selector equals channel number minus one
`timescale 1ns/1ps
`include "dmsc_defines.vh"
module dmsc_monitor (
	// clock, reset, enable
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_ce,
	// ahb-lite slave
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire i_hready,
	input wire [31:0] i_hwdata,
	output reg [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	// received t1 bit stream
	input wire i_rx_valid,
	output wire o_rx_ready,
	input wire i_rx_data,
	input wire i_rx_frame_start,
	input wire i_rx_multiframe_start,
	// receive backplane side
	output wire o_receive_serial_valid,
	input wire i_receive_serial_ready,
	output wire o_receive_serial_out,
	output wire o_receive_serial_frame,
	input wire i_receive_backplane_tick,
	output reg o_receive_signaling_pin,
	output reg o_receive_signaling_strobe,
	// transmit stream
	input wire i_tx_valid,
	input wire i_tx_data,
	input wire i_tx_frame_start,
	input wire i_tx_multiframe_start,
	input wire i_transmit_backplane_tick,
	output reg o_tx_valid,
	output reg o_tx_data,
	// control levels to neighbouring engines
	output wire o_rx_japan_crc6_select
);
	reg [7:0] ctrl6_q;
	reg [7:0] ctrl1_q;
	reg [7:0] mon_q;
	reg [6:0] mon_sh_q;
	reg ralign_prev_q;
	reg talign_prev_q;
	reg wr_pend_q;
	reg [7:0] waddr_q;
	reg [2:0] rbit_q;
	reg [4:0] rchan_q;
	reg [4:0] rfrm_q;
	reg [2:0] tbit_q;
	reg [4:0] tchan_q;
	reg [4:0] tfrm_q;
	reg [8:0] res_wr_q;
	reg [8:0] res_rd_q;
	reg [8:0] tes_wr_q;
	reg [8:0] tes_rd_q;
	reg [31:0] rd_val;
	wire [95:0] rs_flat;
	wire [95:0] ts_flat;
	wire [95:0] txsh_flat;
	wire take;
	wire addr_ok;
	wire [7:0] ridx;
	wire wr_en;
	wire [7:0] wbyte;
	wire [4:0] sel;
	wire force1;
	wire buf_in_ready;
	wire rx_take;
	wire rx_data_bit;
	wire [4:0] rsig;
	wire [3:0] rsig_idx;
	wire rx_robbed;
	wire rx_out_bit;
	wire rx_mf_edge;
	wire tx_take;
	wire tx_data_bit;
	wire [4:0] tsig;
	wire [3:0] tsig_idx;
	wire tx_robbed;
	wire tx_mf_edge;
	wire ralign_go;
	wire talign_go;
	wire [8:0] res_sep;
	wire [8:0] tes_sep;

	// {is signaling frame, first register index of that signaling letter}
	function [4:0] sig_base;
		input [4:0] frm;
		begin
			case (frm)
				5'd5: sig_base = {1'b1, 4'd0};
				5'd11: sig_base = {1'b1, 4'd3};
				5'd17: sig_base = {1'b1, 4'd6};
				5'd23: sig_base = {1'b1, 4'd9};
				default: sig_base = 5'd0;
			endcase
		end
	endfunction

	// pointer separation modulo the store depth
	function [8:0] es_sep;
		input [8:0] w;
		input [8:0] r;
		reg [9:0] t;
		begin
			t = {1'b0, w} + `DMSC_ES_DEPTH - {1'b0, r};
			if (w >= r)
				es_sep = w - r;
			else
				es_sep = t[8:0];
		end
	endfunction

	// read pointer placed half a frame behind the write pointer
	function [8:0] es_behind;
		input [8:0] w;
		reg [9:0] t;
		begin
			t = {1'b0, w} + `DMSC_ES_DEPTH - {1'b0, `DMSC_ES_HALF};
			if (w >= `DMSC_ES_HALF)
				es_behind = w - `DMSC_ES_HALF;
			else
				es_behind = t[8:0];
		end
	endfunction

	function [8:0] es_inc;
		input [8:0] p;
		begin
			es_inc = (p == `DMSC_ES_LAST) ? 9'h000 : p + 9'h001;
		end
	endfunction

	// bus slave: zero wait states, stalls only while the enable is low
	assign o_hreadyout = i_ce;
	assign o_hresp = `DMSC_HRESP_OKAY;
	assign take = i_hsel & i_hready & i_htrans[1] & i_ce;
	assign addr_ok = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'b00);
	assign ridx = addr_ok ? i_haddr[9:2] : 8'hff;
	assign wr_en = wr_pend_q & i_ce;
	assign wbyte = i_hwdata[7:0];

	// control fields
	assign sel = ctrl6_q[`DMSC_SEL_MSB:`DMSC_SEL_LSB];
	assign force1 = ctrl1_q[`DMSC_FORCE1_BIT];
	assign o_rx_japan_crc6_select = ctrl6_q[`DMSC_JCRC_BIT];

	// receive position decode
	assign rx_take = i_rx_valid & buf_in_ready & i_ce;
	assign rx_data_bit = rx_take & ~i_rx_frame_start & (rchan_q < `DMSC_CH_COUNT);
	assign rsig = sig_base(rfrm_q);
	assign rsig_idx = rsig[3:0] + {2'b00, rchan_q[4:3]};
	assign rx_robbed = rx_data_bit & rsig[4] & (rbit_q == `DMSC_BIT_LAST);
	assign rx_mf_edge = rx_take & i_rx_frame_start & i_rx_multiframe_start;
	// forced ones only where a signaling bit was robbed
	assign rx_out_bit = (rx_robbed & force1) ? 1'b1 : i_rx_data;

	// transmit position decode
	assign tx_take = i_tx_valid & i_ce;
	assign tx_data_bit = tx_take & ~i_tx_frame_start & (tchan_q < `DMSC_CH_COUNT);
	assign tsig = sig_base(tfrm_q);
	assign tsig_idx = tsig[3:0] + {2'b00, tchan_q[4:3]};
	assign tx_robbed = tx_data_bit & tsig[4] & (tbit_q == `DMSC_BIT_LAST);
	assign tx_mf_edge = tx_take & i_tx_frame_start & i_tx_multiframe_start;

	// align acts on a clear-to-set transition of the stored bit
	assign ralign_go = ctrl6_q[`DMSC_RALIGN_BIT] & ~ralign_prev_q;
	assign talign_go = ctrl6_q[`DMSC_TALIGN_BIT] & ~talign_prev_q;
	assign res_sep = es_sep(res_wr_q, res_rd_q);
	assign tes_sep = es_sep(tes_wr_q, tes_rd_q);

	// per-register signaling storage
	genvar gi;
	generate
		for (gi = 0; gi < `DMSC_SIG_REGS; gi = gi + 1) begin : g_sig
			reg [7:0] rxsh_q;
			reg [7:0] rs_q;
			reg [7:0] ts_q;
			reg [7:0] txsh_q;
			always @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					rxsh_q <= `DMSC_SIG_RST;
					rs_q <= `DMSC_SIG_RST;
					ts_q <= `DMSC_SIG_RST;
					txsh_q <= `DMSC_SIG_RST;
				end else if (i_ce) begin
					// collect robbed bits, publish whole multiframe at once
					if (rx_robbed && rsig_idx == gi)
						rxsh_q[rchan_q[2:0]] <= i_rx_data;
					if (rx_mf_edge)
						rs_q <= rxsh_q;
					if (wr_en && waddr_q == `DMSC_IDX_TS_FIRST + gi)
						ts_q <= wbyte;
					// software may rewrite ts freely; transmit sees a frozen copy
					if (tx_mf_edge)
						txsh_q <= ts_q;
				end
			end
			assign rs_flat[gi*8 +: 8] = rs_q;
			assign ts_flat[gi*8 +: 8] = ts_q;
			assign txsh_flat[gi*8 +: 8] = txsh_q;
		end
	endgenerate

	// read mux, forwarding a write that completes on the same edge
	always @* begin
		rd_val = 32'h00000000;
		case (ridx)
			`DMSC_IDX_CTRL6: begin
				rd_val[7:0] = (wr_en && waddr_q == ridx) ? wbyte : ctrl6_q;
			end
			`DMSC_IDX_MON: begin
				rd_val[7:0] = mon_q;
			end
			`DMSC_IDX_CTRL1: begin
				rd_val[7:0] = (wr_en && waddr_q == ridx) ? wbyte : ctrl1_q;
			end
			`DMSC_IDX_ESTAT: begin
				rd_val = {7'h00, tes_sep, 7'h00, res_sep};
			end
			default: begin
				if (ridx >= `DMSC_IDX_RS_FIRST && ridx <= `DMSC_IDX_RS_LAST)
					rd_val[7:0] = rs_flat[(ridx - `DMSC_IDX_RS_FIRST)*8 +: 8];
				else if (ridx >= `DMSC_IDX_TS_FIRST && ridx <= `DMSC_IDX_TS_LAST) begin
					if (wr_en && waddr_q == ridx)
						rd_val[7:0] = wbyte;
					else
						rd_val[7:0] = ts_flat[(ridx - `DMSC_IDX_TS_FIRST)*8 +: 8];
				end
			end
		endcase
	end

	// bus phases and control registers
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h00000000;
			wr_pend_q <= 1'b0;
			waddr_q <= 8'h00;
			ctrl6_q <= `DMSC_CTRL6_RST;
			ctrl1_q <= `DMSC_CTRL1_RST;
			ralign_prev_q <= 1'b0;
			talign_prev_q <= 1'b0;
		end else if (i_ce) begin
			wr_pend_q <= take & i_hwrite & (i_hsize == `DMSC_HSIZE_WORD);
			waddr_q <= ridx;
			if (take && !i_hwrite)
				o_hrdata <= rd_val;
			if (wr_en && waddr_q == `DMSC_IDX_CTRL6)
				ctrl6_q <= wbyte;
			if (wr_en && waddr_q == `DMSC_IDX_CTRL1)
				ctrl1_q <= wbyte;
			ralign_prev_q <= ctrl6_q[`DMSC_RALIGN_BIT];
			talign_prev_q <= ctrl6_q[`DMSC_TALIGN_BIT];
		end
	end

	// receive frame position counters
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rbit_q <= 3'd0;
			rchan_q <= 5'd0;
			rfrm_q <= 5'd0;
		end else if (rx_take) begin
			if (i_rx_frame_start) begin
				rbit_q <= 3'd0;
				rchan_q <= 5'd0;
				if (i_rx_multiframe_start || rfrm_q == `DMSC_FRM_LAST)
					rfrm_q <= 5'd0;
				else
					rfrm_q <= rfrm_q + 5'd1;
			end else if (rchan_q < `DMSC_CH_COUNT) begin
				rbit_q <= rbit_q + 3'd1;
				// channel index is selector value, i.e. channel number minus one
				if (rbit_q == `DMSC_BIT_LAST)
					rchan_q <= rchan_q + 5'd1;
			end
		end
	end

	// channel monitor: shift selected byte msb first, commit at its last bit
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mon_sh_q <= 7'h00;
			mon_q <= `DMSC_MON_RST;
		end else if (rx_data_bit && rchan_q == sel) begin
			// out-of-range selectors never match, so the byte holds
			mon_sh_q <= {mon_sh_q[5:0], i_rx_data};
			if (rbit_q == `DMSC_BIT_LAST)
				mon_q <= {mon_sh_q, i_rx_data};
		end
	end

	// pin signaling runs beside the registers, neither gates the other
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_receive_signaling_pin <= 1'b0;
			o_receive_signaling_strobe <= 1'b0;
		end else if (i_ce) begin
			o_receive_signaling_strobe <= rx_robbed;
			if (rx_robbed)
				o_receive_signaling_pin <= i_rx_data;
		end
	end

	// received stream toward the backplane; back-pressure stalls intake
	dmsc_pair_buffer #(
		.WIDTH(2)
	) u_rx_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_in_valid(i_rx_valid),
		.o_in_ready(buf_in_ready),
		.i_in_data({i_rx_frame_start, rx_out_bit}),
		.o_out_valid(o_receive_serial_valid),
		.i_out_ready(i_receive_serial_ready),
		.o_out_data({o_receive_serial_frame, o_receive_serial_out})
	);
	assign o_rx_ready = buf_in_ready;

	// transmit counters and robbed-bit insertion
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tbit_q <= 3'd0;
			tchan_q <= 5'd0;
			tfrm_q <= 5'd0;
			o_tx_valid <= 1'b0;
			o_tx_data <= 1'b0;
		end else if (i_ce) begin
			o_tx_valid <= tx_take;
			if (tx_take) begin
				if (tx_robbed)
					o_tx_data <= txsh_flat[{tsig_idx, tchan_q[2:0]}];
				else
					o_tx_data <= i_tx_data;
				if (i_tx_frame_start) begin
					tbit_q <= 3'd0;
					tchan_q <= 5'd0;
					if (i_tx_multiframe_start || tfrm_q == `DMSC_FRM_LAST)
						tfrm_q <= 5'd0;
					else
						tfrm_q <= tfrm_q + 5'd1;
				end else if (tchan_q < `DMSC_CH_COUNT) begin
					tbit_q <= tbit_q + 3'd1;
					if (tbit_q == `DMSC_BIT_LAST)
						tchan_q <= tchan_q + 5'd1;
				end
			end
		end
	end

	// elastic store pointers; align only pulls a too-close pair apart
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			res_wr_q <= 9'h000;
			res_rd_q <= 9'h000;
			tes_wr_q <= 9'h000;
			tes_rd_q <= 9'h000;
		end else if (i_ce) begin
			if (rx_take)
				res_wr_q <= es_inc(res_wr_q);
			if (ralign_go && res_sep < `DMSC_ES_HALF)
				res_rd_q <= es_behind(res_wr_q);
			else if (i_receive_backplane_tick)
				res_rd_q <= es_inc(res_rd_q);
			if (i_transmit_backplane_tick)
				tes_wr_q <= es_inc(tes_wr_q);
			if (talign_go && tes_sep < `DMSC_ES_HALF)
				tes_rd_q <= es_behind(tes_wr_q);
			else if (tx_take)
				tes_rd_q <= es_inc(tes_rd_q);
		end
	end
endmodule // dmsc_monitor

//--- testbench/dmsc_monitor_chk.sv
`timescale 1ns/1ps
module dmsc_monitor_chk (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_ce,
	// bus
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire i_hready,
	input wire [31:0] i_hwdata,
	input wire o_hreadyout,
	input wire o_hresp,
	// streams
	input wire i_rx_valid,
	input wire o_rx_ready,
	input wire o_receive_serial_valid,
	input wire i_receive_serial_ready,
	input wire o_receive_serial_out,
	input wire o_receive_serial_frame,
	input wire o_receive_signaling_pin,
	input wire o_receive_signaling_strobe,
	input wire i_tx_valid,
	input wire o_tx_valid,
	input wire o_rx_japan_crc6_select
);
	logic [1:0] fill_q;
	logic wr6_q;
	logic wdone_q;
	logic crc_q;
	wire push_w = i_ce & i_rx_valid & o_rx_ready;
	wire pop_w = i_ce & o_receive_serial_valid & i_receive_serial_ready;
	wire wr6_w = i_ce & i_hsel & i_hready & i_htrans[1] & i_hwrite & (i_haddr == 32'h78);
	// buffer fill mirror and pending control write, used to bound outputs
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fill_q <= 2'd0;
			wr6_q <= 1'b0;
			wdone_q <= 1'b0;
			crc_q <= 1'b0;
		end else begin
			fill_q <= fill_q + {1'b0, push_w} - {1'b0, pop_w};
			// the design freezes its pending write while the enable is low
			wr6_q <= i_ce ? (wr6_w & (i_hsize == 3'b010)) : wr6_q;
			wdone_q <= wr6_q & i_ce;
			crc_q <= (wr6_q & i_ce) ? i_hwdata[7] : crc_q;
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	ready_follows_ce_a: assert property (o_hreadyout == i_ce)
		else $error("hreadyout differs from enable");
	okay_only_a: assert property (o_hresp == 1'b0)
		else $error("response other than okay");
	crc_follow_a: assert property (wdone_q |-> ##[0:1] o_rx_japan_crc6_select == crc_q)
		else $error("crc select does not follow write");
	crc_hold_a: assert property (!$stable(o_rx_japan_crc6_select) |-> wdone_q || $past(wdone_q))
		else $error("crc select moved without write");
	fill_valid_a: assert property (o_receive_serial_valid == (fill_q != 2'd0))
		else $error("serial valid disagrees with fill");
	fill_refuse_a: assert property (o_rx_ready == (fill_q != 2'd2))
		else $error("line ready disagrees with fill");
	serial_hold_a: assert property (o_receive_serial_valid && !i_receive_serial_ready |=>
		o_receive_serial_valid && $stable(o_receive_serial_out) && $stable(o_receive_serial_frame))
		else $error("serial output changed while stalled");
	tx_pulse_a: assert property (i_tx_valid && i_ce |=> o_tx_valid)
		else $error("transmit bit not passed on");
	tx_cause_a: assert property (o_tx_valid && $past(i_ce) |-> $past(i_tx_valid))
		else $error("transmit valid without input");
	strobe_cause_a: assert property (o_receive_signaling_strobe && $past(i_ce) |-> $past(push_w))
		else $error("signaling strobe without taken bit");
	pin_moves_a: assert property (!$stable(o_receive_signaling_pin) |-> ##[0:1] o_receive_signaling_strobe)
		else $error("signaling pin moved without strobe");
	cover property (!o_rx_ready);
	cover property (o_receive_serial_valid && !i_receive_serial_ready);
	cover property (o_receive_signaling_strobe);
	cover property (wdone_q && crc_q);
endmodule // dmsc_monitor_chk

bind dmsc_monitor dmsc_monitor_chk chk_u (.i_clk_sys, .i_rst_n, .i_ce, .i_hsel, .i_haddr,
	.i_htrans, .i_hwrite, .i_hsize, .i_hready, .i_hwdata, .o_hreadyout, .o_hresp, .i_rx_valid,
	.o_rx_ready, .o_receive_serial_valid, .i_receive_serial_ready, .o_receive_serial_out,
	.o_receive_serial_frame, .o_receive_signaling_pin, .o_receive_signaling_strobe,
	.i_tx_valid, .o_tx_valid, .o_rx_japan_crc6_select);

//--- testbench/dmsc_line_model.sv
`timescale 1ns/1ps
module dmsc_line_model (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_n,
	// bench control
	input wire i_start,
	input wire i_force1,
	// line side
	output wire o_rx_valid,
	input wire i_rx_ready,
	output wire o_rx_data,
	output wire o_rx_frame_start,
	output wire o_rx_multiframe_start,
	// backplane side
	input wire i_serial_valid,
	output logic o_serial_ready,
	input wire i_serial_out,
	input wire i_serial_frame,
	// transmit side: echoed stream with inserted signaling
	input wire i_tx_valid,
	input wire i_tx_data,
	input wire [7:0] i_ts_first,
	// status
	output wire o_busy,
	output int o_errs,
	output int o_seen
);
	logic run_q;
	int pos;
	int frm;
	int pend;
	logic [1:0] tick_q;
	logic tx_exp_q;
	logic [1:0] exp_q [$];
	wire [7:0] byte_w = {3'b110, 5'((pos - 1) / 8 + 1)};
	wire robbed_w = (frm % 6 == 5) && (pos > 0) && ((pos - 1) % 8 == 7);
	wire bit_w = (pos == 0) ? 1'b1 : byte_w[7 - (pos - 1) % 8];
	// channel minus one; only the first signaling register holds ones
	wire [4:0] ch0_w = 5'((pos - 1) / 8);
	wire ts_bit_w = (frm == 5 && ch0_w < 5'd8) ? i_ts_first[ch0_w[2:0]] : 1'b0;
	wire tx_exp_w = robbed_w ? ts_bit_w : bit_w;
	// idle line toggles so a stale bit is never mistaken for data
	assign o_rx_data = run_q ? bit_w : tick_q[0];
	assign o_rx_valid = run_q;
	assign o_rx_frame_start = run_q && pos == 0;
	assign o_rx_multiframe_start = run_q && pos == 0 && frm == 0;
	assign o_busy = run_q || pend != 0;
	// one multiframe per start; backplane stalls one cycle in four
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_q <= 1'b0;
			pos <= 0;
			frm <= 0;
			pend <= 0;
			tick_q <= 2'd0;
			tx_exp_q <= 1'b0;
			o_serial_ready <= 1'b0;
			o_errs <= 0;
			o_seen <= 0;
		end else begin
			tick_q <= tick_q + 2'd1;
			o_serial_ready <= tick_q != 2'd3;
			pend <= pend + (run_q && i_rx_ready) - (i_serial_valid && o_serial_ready);
			if (i_start && !o_busy) run_q <= 1'b1;
			// serial and transmit mismatches share one count
			o_errs <= o_errs + int'(i_serial_valid && o_serial_ready &&
				(exp_q.size() == 0 || exp_q[0] !== {i_serial_frame, i_serial_out})) +
				int'(i_tx_valid && i_tx_data !== tx_exp_q);
			if (i_serial_valid && o_serial_ready) begin
				o_seen <= o_seen + 1;
				if (exp_q.size() != 0) exp_q.pop_front();
			end
			if (run_q && i_rx_ready) begin
				exp_q.push_back({o_rx_frame_start, bit_w | (robbed_w & i_force1)});
				tx_exp_q <= tx_exp_w;
				pos <= (pos == 192) ? 0 : pos + 1;
				if (pos == 192) frm <= (frm == 23) ? 0 : frm + 1;
				if (pos == 192 && frm == 23) run_q <= 1'b0;
			end
		end
	end
endmodule // dmsc_line_model

//--- testbench/dmsc_monitor_tb.sv
`timescale 1ns/1ps
module dmsc_monitor_tb;
	logic i_clk_sys;
	logic i_rst_n;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic start;
	logic force1;
	logic ce;
	logic [31:0] rd;
	wire [31:0] hrdata;
	wire hready, hresp, rx_valid, rx_ready, rx_data, rx_fs, rx_mfs, busy;
	wire sv, sr, so, sf, sig_pin, sig_stb, tx_v, tx_d, crc;
	wire take = rx_valid & rx_ready;
	int errs, seen, n, n_mismatch, num_checks;
	logic [31:0] rst_a [7] = '{32'h78, 32'h7c, 32'h100, 32'h104, 32'h180, 32'h1c0, 32'h3f0};
	logic [7:0] sel_t [3] = '{8'd14, 8'd23, 8'd24};
	logic [7:0] mon_t [3] = '{8'hcf, 8'hd8, 8'hd8};
	dmsc_monitor dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(ce), .i_hsel(1'b1),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
		.i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .i_rx_data(rx_data),
		.i_rx_frame_start(rx_fs), .i_rx_multiframe_start(rx_mfs), .o_receive_serial_valid(sv),
		.i_receive_serial_ready(sr), .o_receive_serial_out(so), .o_receive_serial_frame(sf),
		.i_receive_backplane_tick(take), .o_receive_signaling_pin(sig_pin),
		.o_receive_signaling_strobe(sig_stb), .i_tx_valid(take), .i_tx_data(rx_data),
		.i_tx_frame_start(rx_fs), .i_tx_multiframe_start(rx_mfs),
		.i_transmit_backplane_tick(take), .o_tx_valid(tx_v), .o_tx_data(tx_d),
		.o_rx_japan_crc6_select(crc));
	dmsc_line_model line_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(start),
		.i_force1(force1), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_data(rx_data),
		.o_rx_frame_start(rx_fs), .o_rx_multiframe_start(rx_mfs), .i_serial_valid(sv),
		.o_serial_ready(sr), .i_serial_out(so), .i_serial_frame(sf), .i_tx_valid(tx_v),
		.i_tx_data(tx_d), .i_ts_first(8'ha5), .o_busy(busy),
		.o_errs(errs), .o_seen(seen));
	// 50 MHz
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	task automatic complete_run();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// single word transfer; address phase held until hready, data then held likewise
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		n = 0;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge i_clk_sys); while (hready !== 1'b1 && ++n < 40);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge i_clk_sys); while (hready !== 1'b1 && ++n < 40);
		rd = hrdata;
		if (n >= 40) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask
	initial begin
		i_rst_n = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		start = 1'b0;
		force1 = 1'b0;
		ce = 1'b1;
		n_mismatch = 0;
		num_checks = 0;
		repeat (12) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(posedge i_clk_sys);
		foreach (rst_a[i]) rd_chk(rst_a[i], 32'h0, "reset value");
		bus(1'b1, 32'h1c0, 32'ha5);
		rd_chk(32'h1c0, 32'ha5, "tx signaling");
		bus(1'b1, 32'h3f0, 32'hff);
		rd_chk(32'h3f0, 32'h0, "unmapped");
		bus(1'b1, 32'h78, 32'hee);
		rd_chk(32'h78, 32'hee, "control six");
		check("crc select", 32'h1, {31'h0, crc});
		rd_chk(32'h104, 32'h00610061, "pointer gap");
		bus(1'b1, 32'h78, 32'h0e);
		rd_chk(32'h78, 32'h0e, "control six");
		check("crc select", 32'h0, {31'h0, crc});
		// one multiframe per pass: monitor select and forcing vary
		for (int p = 0; p < 3; p++) begin
			bus(1'b1, 32'h78, {24'h0, sel_t[p]});
			force1 <= (p == 1);
			bus(1'b1, 32'h100, (p == 1) ? 32'h20 : 32'h0);
			start <= 1'b1;
			@(posedge i_clk_sys);
			start <= 1'b0;
			n = 0;
			do @(posedge i_clk_sys); while (busy && ++n < 20000);
			if (n >= 20000) begin
				n_mismatch++;
				complete_run();
			end
			check("serial errors", 32'h0, 32'(errs));
			check("serial bits", 32'(4632 * (p + 1)), 32'(seen));
			rd_chk(32'h7c, {24'h0, mon_t[p]}, "monitor byte");
		end
		bus(1'b1, 32'h180, 32'h0);
		rd_chk(32'h180, 32'h55, "rx signaling first");
		rd_chk(32'h1ac, 32'h55, "rx signaling last");
		// enable low for three edges: the address phase must wait it out
		ce <= 1'b0;
		fork
			begin
				repeat (3) @(posedge i_clk_sys);
				ce <= 1'b1;
			end
		join_none
		rd_chk(32'h104, 32'h00610061, "pointer gap");
		complete_run();
	end
endmodule // dmsc_monitor_tb
